// ---- verification/adc_channel_config_mux_bench.sv ----
// Purpose: self-checking bench for adc_channel_config_mux
// Assumes: one wait state per access, sequencer strobes driven here
// Notes: table rows first, then temp sensor, overlap and reset cases
`timescale 1ns/10ps
module adc_channel_config_mux_bench;
  import chan_mux_pkg::*;
  localparam int CODE_W = 16;
  typedef struct packed {
    logic [1:0] m;
    logic [3:0] c0, wi, wv, ch;
    logic [4:0] ep, en;
    logic eb, eh;
  } row_s;
  logic clk = 0, nrst = 0, read = 0, write = 0, acq_start = 0, acq_temp = 0;
  logic conv_start = 0, conv_done = 0, raw_valid = 0;
  logic [7:0] address = '0;
  logic [31:0] writedata = '0, readdata, q;
  logic [3:0] byteenable = 4'hf, acq_chan = '0;
  logic [CODE_W-1:0] raw_code = '0, result_code;
  logic result_valid, result_bipolar, waitrequest, sample_switch, input_hiz_enable;
  logic [16:0] positive_route_switch;
  logic [17:0] negative_route_switch;
  int errors = 0, n_checks = 0, cyc = 0;
  // ch0 written before wi, so wi is never 0
  row_s rows[9] = '{
    '{SEQ_STANDARD, 4'h0, 4'h5, 4'h5, 4'h5, 5'h05, 5'h11, 1'b0, 1'b0},
    '{SEQ_STANDARD, 4'h9, 4'h3, 4'h4, 4'h3, 5'h03, 5'h10, 1'b1, 1'b1},
    '{SEQ_ADVANCED, 4'h9, 4'h3, 4'h4, 4'h3, 5'h03, 5'h11, 1'b0, 1'b0},
    '{SEQ_ADVANCED, 4'h0, 4'h6, 4'he, 4'h7, 5'h06, 5'h07, 1'b1, 1'b1},
    '{SEQ_TWO_CYCLE, 4'h0, 4'h6, 4'h6, 4'h6, 5'h06, 5'h07, 1'b1, 1'b0},
    '{SEQ_SINGLE_CYCLE, 4'h0, 4'ha, 4'h5, 4'ha, 5'h0a, 5'h10, 1'b1, 1'b0},
    '{SEQ_SINGLE_CYCLE, 4'h0, 4'hb, 4'h7, 4'hb, 5'h0b, 5'h11, 1'b0, 1'b0},
    '{SEQ_STANDARD, 4'h6, 4'h1, 4'h0, 4'h1, 5'h00, 5'h01, 1'b1, 1'b0},
    '{SEQ_ADVANCED, 4'h0, 4'hf, 4'h1, 4'hf, 5'h0f, 5'h10, 1'b0, 1'b0}};

  adc_channel_config_mux #(.CODE_W(CODE_W)) i_dut (.clk, .nrst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .acq_start, .acq_chan, .acq_temp, .conv_start, .conv_done,
    .raw_code, .raw_valid, .result_code, .result_valid, .result_bipolar, .positive_route_switch,
    .negative_route_switch, .sample_switch, .input_hiz_enable);

  always #5 clk = ~clk;

  // run is about 340 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    r = readdata;
    read <= 0;
    write <= 0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  // mid: rewrite ch2 and retry a start while acquiring
  task automatic acq(input logic [3:0] ch, input logic t, input logic [4:0] ep, input logic [4:0] en,
                     input logic eb, input logic eh, input logic mid);
    int n;
    n = 0;
    acq_start <= 1;
    acq_chan <= ch;
    acq_temp <= t;
    @(posedge clk);
    acq_start <= 0;
    acq_temp <= 0;
    #1 chk(positive_route_switch | negative_route_switch, 0);
    @(posedge clk);
    #1 chk(positive_route_switch, 17'h1 << ep);
    chk(negative_route_switch, 18'h1 << en);
    chk(result_bipolar, eb);
    chk(input_hiz_enable, eh);
    while (!sample_switch && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n, eh ? HIZ_CLOSE_CYCLES : 0);
    @(posedge clk);
    if (mid) begin
      wr(CFG_BASE_ADDR + 8'h08, 32'h0000_0008);
      acq_start <= 1;
      acq_chan <= 4'h4;
      @(posedge clk);
      acq_start <= 0;
    end
    conv_start <= 1;
    raw_code <= 16'ha5c3;
    raw_valid <= 1;
    @(posedge clk);
    conv_start <= 0;
    raw_valid <= 0;
    #1 chk({result_valid, result_code}, {1'b1, 16'ha5c3 ^ {eb, 15'h0000}});
    chk({sample_switch, input_hiz_enable, positive_route_switch}, {1'b0, eh, 17'h1 << ep});
    @(posedge clk);
    conv_done <= 1;
    @(posedge clk);
    conv_done <= 0;
  endtask : acq

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    #1 chk({waitrequest, positive_route_switch, negative_route_switch}, {1'b1, 35'h0});
    @(posedge clk);
    bus(1'b0, CFG_BASE_ADDR + 8'h3c, '0, q);
    chk(q, {28'h0, CFG_RESET});
    bus(1'b0, CTRL_ADDR, '0, q);
    chk(q, {30'h0, CTRL_RESET});
    foreach (rows[i]) begin
      wr(CTRL_ADDR, {30'h0, rows[i].m});
      wr(CFG_BASE_ADDR, {28'h0, rows[i].c0});
      wr(CFG_BASE_ADDR + {2'h0, rows[i].wi, 2'h0}, {28'h0, rows[i].wv});
      bus(1'b0, CFG_BASE_ADDR + {2'h0, rows[i].wi, 2'h0}, '0, q);
      chk(q, {28'h0, rows[i].wv});
      acq(rows[i].ch, 1'b0, rows[i].ep, rows[i].en, rows[i].eb, rows[i].eh, 1'b0);
    end
    acq(4'h6, 1'b0, 5'h06, 5'h07, 1'b1, 1'b0, 1'b0);
    acq(4'h0, 1'b1, 5'h10, 5'h11, 1'b0, 1'b1, 1'b0);
    wr(8'h80, 32'hffff_ffff);
    bus(1'b0, 8'h80, '0, q);
    chk(q, 0);
    byteenable <= 4'h0;
    wr(CFG_BASE_ADDR + 8'h08, 32'h0000_000f);
    byteenable <= 4'hf;
    acq(4'h2, 1'b0, 5'h02, 5'h11, 1'b0, 1'b0, 1'b1);
    bus(1'b0, STATUS_ADDR, '0, q);
    chk(q, 32'h0000_1420);
    bus(1'b0, STATUS_ADDR, '0, q);
    chk(q, 32'h0000_1020);
    wr(CTRL_ADDR, {30'h0, SEQ_STANDARD});
    wr(CFG_BASE_ADDR, 32'h0000_0008);
    acq(4'h9, 1'b0, 5'h09, 5'h11, 1'b0, 1'b1, 1'b0);
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    #1 chk({waitrequest, input_hiz_enable, result_bipolar}, 3'b100);
    chk({positive_route_switch, negative_route_switch}, 35'h0);
    @(posedge clk);
    bus(1'b0, CFG_BASE_ADDR, '0, q);
    chk(q, {28'h0, CFG_RESET});
    bus(1'b0, CTRL_ADDR, '0, q);
    chk(q, {30'h0, CTRL_RESET});
    final_report();
  end
endmodule : adc_channel_config_mux_bench

bind adc_channel_config_mux adc_channel_config_mux_monitor #(.CODE_W(CODE_W)) i_mon (.clk, .nrst, .read,
  .write, .waitrequest, .raw_code, .raw_valid, .result_code, .result_valid, .result_bipolar,
  .positive_route_switch, .negative_route_switch, .sample_switch, .input_hiz_enable);

// ---- verification/adc_channel_config_mux_monitor.sv ----
// Purpose: port-level checks for adc_channel_config_mux
// Assumes: one clock, nrst async active low
// Notes: bound from the bench file
`timescale 1ns/10ps
module adc_channel_config_mux_monitor #(
  parameter int CODE_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // results
  input wire logic [CODE_W-1:0] raw_code,
  input wire logic raw_valid,
  input wire logic [CODE_W-1:0] result_code,
  input wire logic result_valid,
  input wire logic result_bipolar,
  // switches
  input wire logic [16:0] positive_route_switch,
  input wire logic [17:0] negative_route_switch,
  input wire logic sample_switch,
  input wire logic input_hiz_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_pos_one_hot: assert property ($onehot0(positive_route_switch))
    else $error("positive switch not one-hot");
  a_neg_one_hot: assert property ($onehot0(negative_route_switch))
    else $error("negative switch not one-hot");
  a_break_first: assert property ((positive_route_switch != 0 && $changed(positive_route_switch)) ||
    (negative_route_switch != 0 && $changed(negative_route_switch))
    |-> $past(positive_route_switch) == 0 && $past(negative_route_switch) == 0)
    else $error("switch closed without break");
  a_ground_unipolar: assert property (negative_route_switch[17] |-> !result_bipolar)
    else $error("bipolar against ground");
  a_temp_hiz: assert property (positive_route_switch[16] |-> input_hiz_enable && negative_route_switch[17])
    else $error("temp sensor without high-z");
  a_close_now: assert property ($rose(|positive_route_switch) && !input_hiz_enable |-> sample_switch)
    else $error("sample switch late");
  a_close_late: assert property ($rose(|positive_route_switch) && input_hiz_enable |-> !sample_switch [*8])
    else $error("sample switch early");
  a_result_format: assert property (raw_valid |=> result_valid &&
    result_code == ($past(raw_code) ^ {result_bipolar, {(CODE_W-1){1'b0}}}))
    else $error("result format wrong");
  a_settings_held: assert property (|positive_route_switch && $past(|positive_route_switch)
    |-> $stable(input_hiz_enable) && $stable(result_bipolar))
    else $error("latched settings changed");
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus wait not one cycle");
endmodule : adc_channel_config_mux_monitor

// ---- verilog/adc_channel_config_mux.sv ----
// Purpose: channel configuration registers and mux switch control for a 16-input SAR converter
// Assumes: sequencer strobes and raw codes come from logic on the same clock
// Notes: one Avalon wait state on every access
//
// Notes on behaviour
// - any of 16 inputs or the temperature sensor can reach the positive core input
// - both route switches open fully before new ones close; only sequencing logic drives them
// - each of the 16 inputs has its own pairing and polarity configuration
// - negative core input comes from reference ground, common pin, or next odd input
// - unipolar results are straight binary, pseudobipolar results two's complement
// - pairing from the pairing field, polarity from the polarity field of config registers
// - selecting the odd input of a configured pair acts like selecting the even one
// - in a pair even drives positive, odd negative; only the even config applies
// - standard sequencer: all inputs use channel zero's pairing
// - other sequencing modes: each input uses its own pairing
// - polarity always comes from the input's own configuration
// - reference ground pairing forces unipolar operation
// - standard sequencer: high-Z enable for all inputs comes from channel zero
// - other sequencing modes: each input's high-Z enable is its own
// - high-Z mode is forced on while sampling the temperature sensor
// - high-Z on: sample switches close partway into acquisition; off: at once
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module adc_channel_config_mux #(
  parameter int CODE_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // sequencer strobes
  input wire logic acq_start,
  input wire logic [3:0] acq_chan,
  input wire logic acq_temp,
  input wire logic conv_start,
  input wire logic conv_done,
  // raw core codes
  input wire logic [CODE_W-1:0] raw_code,
  input wire logic raw_valid,
  // formatted results
  output logic [CODE_W-1:0] result_code,
  output logic result_valid,
  output logic result_bipolar,
  // switch controls
  output logic [16:0] positive_route_switch,
  output logic [17:0] negative_route_switch,
  output logic sample_switch,
  output logic input_hiz_enable
);
  import chan_mux_pkg::*;

  // port widths below are fixed for sixteen inputs and a four-bit channel index
  if (NUM_INPUTS != 16) begin : g_bad_inputs
    $error("NUM_INPUTS must be 16");
  end
  if (CODE_W < 2 || CODE_W > 24) begin : g_bad_code_w
    $error("CODE_W out of range");
  end
  // the high-Z delay counter must be able to reach its limit
  if (HIZ_CLOSE_CYCLES < 1 || HIZ_CLOSE_CYCLES >= 2 ** CNT_W) begin : g_bad_hiz_cnt
    $error("HIZ_CLOSE_CYCLES does not fit CNT_W");
  end

  typedef struct packed {
    phase_e phase;
    logic [CNT_W-1:0] cnt;
    logic [3:0] lat_chan;
    logic lat_temp;
    cfg_s lat_cfg;
    logic [16:0] pos_sw;
    logic [17:0] neg_sw;
    logic sample_sw;
    logic [1:0] seq_mode;
    logic overlap_err;
    logic [31:0] rdata;
    logic waitreq;
    logic [CODE_W-1:0] result;
    logic result_vld;
  } state_s;

  state_s s_reg;
  state_s s_next;

  chan_cfg_if cfg_bus ();

  chan_cfg_store u_store (
    .clk(clk),
    .nrst(nrst),
    .cfg(cfg_bus.store)
  );

  // resolving the selected channel
  logic standard_mode;
  logic [3:0] even_chan;
  logic [1:0] even_pair;
  logic use_even;
  cfg_s base_cfg;
  logic [3:0] route_chan;
  cfg_s eff_cfg;
  logic [16:0] dec_pos;
  logic [17:0] dec_neg;

  assign standard_mode = (s_reg.seq_mode == SEQ_STANDARD);
  assign even_chan = {acq_chan[3:1], 1'b0};
  assign cfg_bus.sel_idx = acq_chan;
  assign cfg_bus.even_idx = even_chan;

  always_comb begin
    // pairing of the even neighbour, or of channel zero in standard mode, decides whether an odd pick folds back
    even_pair = standard_mode ? cfg_bus.zero_cfg.pair : cfg_bus.even_cfg.pair;
    use_even = acq_chan[0] && (even_pair == PAIR_EVEN_ODD);
    base_cfg = use_even ? cfg_bus.even_cfg : cfg_bus.sel_cfg;
    route_chan = use_even ? even_chan : acq_chan;
    eff_cfg = base_cfg;
    if (standard_mode) begin
      eff_cfg.pair = cfg_bus.zero_cfg.pair;
      eff_cfg.hiz = cfg_bus.zero_cfg.hiz;
    end else begin
      eff_cfg.pair = base_cfg.pair;
      eff_cfg.hiz = base_cfg.hiz;
    end
    // odd input with its own even/odd pairing has no neighbour above it
    if (route_chan[0] && eff_cfg.pair == PAIR_EVEN_ODD) begin
      eff_cfg.pair = PAIR_REF_GROUND;
    end
    // spare pairing code falls back to ground, so polarity is forced unipolar below
    if (!(eff_cfg.pair inside {PAIR_COMMON, PAIR_EVEN_ODD})) begin
      eff_cfg.pair = PAIR_REF_GROUND;
    end
    eff_cfg.bipolar = base_cfg.bipolar;
    if (eff_cfg.pair == PAIR_REF_GROUND) begin
      eff_cfg.bipolar = 1'b0;
    end
    if (acq_temp) begin
      eff_cfg.pair = PAIR_REF_GROUND;
      eff_cfg.bipolar = 1'b0;
      eff_cfg.hiz = 1'b1;
    end
  end

  mux_route_decode u_route (
    .temp_sel(s_reg.lat_temp),
    .chan(s_reg.lat_chan),
    .pair(s_reg.lat_cfg.pair),
    .pos_sw(dec_pos),
    .neg_sw(dec_neg)
  );

  // bus decode
  logic bus_req;
  logic bus_take;
  logic cfg_hit;
  logic ctrl_hit;
  logic status_hit;
  assign bus_req = read || write;
  assign bus_take = bus_req && !s_reg.waitreq;
  assign cfg_hit = (address[7:6] == CFG_BASE_ADDR[7:6]);
  assign ctrl_hit = (address[7:2] == CTRL_ADDR[7:2]);
  assign status_hit = (address[7:2] == STATUS_ADDR[7:2]);
  assign cfg_bus.bus_idx = address[5:2];
  assign cfg_bus.wr_en = bus_take && write && cfg_hit && byteenable[0];
  assign cfg_bus.wr_idx = address[5:2];
  assign cfg_bus.wr_data = writedata[3:0];

  always_comb begin
    s_next = s_reg;
    s_next.result_vld = 1'b0;

    // one wait state, then accept for exactly one edge
    if (bus_req && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = 32'h0000_0000;
      if (cfg_hit) begin
        s_next.rdata[3:0] = cfg_bus.bus_cfg;
      end else if (ctrl_hit) begin
        s_next.rdata[1:0] = s_reg.seq_mode;
      end else if (status_hit) begin
        s_next.rdata[3:0] = s_reg.lat_cfg;
        s_next.rdata[7:4] = s_reg.lat_chan;
        s_next.rdata[8] = s_reg.lat_temp;
        s_next.rdata[9] = s_reg.sample_sw;
        s_next.rdata[10] = s_reg.overlap_err;
        s_next.rdata[15:12] = s_reg.phase;
      end
    end else begin
      s_next.waitreq = 1'b1;
    end

    if (bus_take && write && ctrl_hit && byteenable[0]) begin
      s_next.seq_mode = writedata[1:0];
    end
    // reading status clears the overlap flag; a new overlap still wins
    if (bus_take && read && status_hit) begin
      s_next.overlap_err = 1'b0;
    end

    unique case (s_reg.phase)
      PH_IDLE: begin
        if (acq_start) begin
          s_next.lat_chan = acq_temp ? 4'h0 : route_chan;
          s_next.lat_temp = acq_temp;
          s_next.lat_cfg = eff_cfg;
          s_next.pos_sw = '0;
          s_next.neg_sw = '0;
          s_next.sample_sw = 1'b0;
          s_next.cnt = '0;
          s_next.phase = PH_BREAK;
        end
      end
      PH_BREAK: begin
        // everything is open this cycle, so the new path closes only now
        s_next.pos_sw = dec_pos;
        s_next.neg_sw = dec_neg;
        s_next.sample_sw = !s_reg.lat_cfg.hiz;
        s_next.cnt = CNT_W'(1);
        s_next.phase = PH_ACQ;
      end
      PH_ACQ: begin
        if (s_reg.lat_cfg.hiz && !s_reg.sample_sw) begin
          if (s_reg.cnt >= CNT_W'(HIZ_CLOSE_CYCLES)) begin
            s_next.sample_sw = 1'b1;
          end else begin
            s_next.cnt = s_reg.cnt + CNT_W'(1);
          end
        end
        if (conv_start) begin
          s_next.sample_sw = 1'b0;
          s_next.phase = PH_CONV;
        end
      end
      PH_CONV: begin
        if (conv_done) begin
          s_next.phase = PH_IDLE;
        end
      end
    endcase

    // a strobe in any phase but idle (break, acquisition or conversion) is dropped, latched settings stay put
    if (acq_start && s_reg.phase != PH_IDLE) begin
      s_next.overlap_err = 1'b1;
    end

    if (raw_valid) begin
      s_next.result = raw_code;
      if (s_reg.lat_cfg.bipolar) begin
        s_next.result[CODE_W-1] = !raw_code[CODE_W-1];
      end
      s_next.result_vld = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg.phase <= PH_IDLE;
      s_reg.cnt <= '0;
      s_reg.lat_chan <= 4'h0;
      s_reg.lat_temp <= 1'b0;
      s_reg.lat_cfg <= CFG_RESET;
      s_reg.pos_sw <= '0;
      s_reg.neg_sw <= '0;
      s_reg.sample_sw <= 1'b0;
      s_reg.seq_mode <= CTRL_RESET;
      s_reg.overlap_err <= 1'b0;
      s_reg.rdata <= 32'h0000_0000;
      s_reg.waitreq <= 1'b1;
      s_reg.result <= '0;
      s_reg.result_vld <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata = s_reg.rdata;
  assign waitrequest = s_reg.waitreq;
  assign result_code = s_reg.result;
  assign result_valid = s_reg.result_vld;
  assign result_bipolar = s_reg.lat_cfg.bipolar;
  assign positive_route_switch = s_reg.pos_sw;
  assign negative_route_switch = s_reg.neg_sw;
  assign sample_switch = s_reg.sample_sw;
  assign input_hiz_enable = s_reg.lat_cfg.hiz;
endmodule : adc_channel_config_mux

// ---- verilog/chan_cfg_if.sv ----
// Purpose: carries configuration lookups and writes between control and register store
// Assumes: single clock domain
// Notes: lookups are combinational
`timescale 1ns/10ps
interface chan_cfg_if;
  import chan_mux_pkg::*;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [3:0] wr_data;
  logic [3:0] sel_idx;
  logic [3:0] even_idx;
  logic [3:0] bus_idx;
  cfg_s sel_cfg;
  cfg_s even_cfg;
  cfg_s zero_cfg;
  cfg_s bus_cfg;
  modport store (input wr_en, wr_idx, wr_data, sel_idx, even_idx, bus_idx,
                 output sel_cfg, even_cfg, zero_cfg, bus_cfg);
  modport user (output wr_en, wr_idx, wr_data, sel_idx, even_idx, bus_idx,
                input sel_cfg, even_cfg, zero_cfg, bus_cfg);
endinterface : chan_cfg_if

// ---- verilog/chan_cfg_store.sv ----
// Purpose: one configuration word per analog input
// Assumes: writes come from the bus slave on the same clock
// Notes: four lookup ports, all combinational
`timescale 1ns/10ps
module chan_cfg_store (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // lookups and writes
  chan_cfg_if.store cfg
);
  import chan_mux_pkg::*;

  typedef struct packed {
    logic [NUM_INPUTS-1:0][CFG_W-1:0] word;
  } store_s;

  store_s s_reg;
  store_s s_next;

  always_comb begin
    s_next = s_reg;
    if (cfg.wr_en) begin
      s_next.word[cfg.wr_idx] = cfg.wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg.word <= {NUM_INPUTS{CFG_RESET}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cfg.sel_cfg = cfg_s'(s_reg.word[cfg.sel_idx]);
  assign cfg.even_cfg = cfg_s'(s_reg.word[cfg.even_idx]);
  assign cfg.zero_cfg = cfg_s'(s_reg.word[0]);
  assign cfg.bus_cfg = cfg_s'(s_reg.word[cfg.bus_idx]);
endmodule : chan_cfg_store

// ---- verilog/chan_mux_pkg.sv ----
// Purpose: shared constants and types for the channel configuration and mux control block
// Assumes: 100 MHz clock, 32-bit register bus with byte addresses
// Notes: register fields live in the low bits of each word
package chan_mux_pkg;
  localparam int NUM_INPUTS = 16;
  localparam int CLK_PERIOD_PS = 10000;
  // register byte offsets
  localparam logic [7:0] CFG_BASE_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h40;
  localparam logic [7:0] STATUS_ADDR = 8'h44;
  // channel_config_reg field positions
  localparam int PAIR_LSB = 0;
  localparam int MODE_BIT = 2;
  localparam int HIZ_BIT = 3;
  localparam int CFG_W = 4;
  localparam logic [3:0] CFG_RESET = 4'h0;
  // pairing sources
  localparam logic [1:0] PAIR_REF_GROUND = 2'h0;
  localparam logic [1:0] PAIR_COMMON = 2'h1;
  localparam logic [1:0] PAIR_EVEN_ODD = 2'h2;
  // sequencing modes
  localparam logic [1:0] SEQ_STANDARD = 2'h0;
  localparam logic [1:0] SEQ_ADVANCED = 2'h1;
  localparam logic [1:0] SEQ_TWO_CYCLE = 2'h2;
  localparam logic [1:0] SEQ_SINGLE_CYCLE = 2'h3;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // timing
  localparam int HIZ_CLOSE_DELAY_NS = 250;
  localparam int HIZ_CLOSE_CYCLES = (HIZ_CLOSE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 6;
  // negative and positive switch positions above the inputs
  localparam int NEG_COM_POS = 16;
  localparam int NEG_GND_POS = 17;
  localparam int POS_TEMP_POS = 16;

  typedef struct packed {
    logic hiz;
    logic bipolar;
    logic [1:0] pair;
  } cfg_s;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_BREAK = 4'h2,
    PH_ACQ = 4'h4,
    PH_CONV = 4'h8
  } phase_e;
endpackage : chan_mux_pkg

// ---- verilog/mux_route_decode.sv ----
// Purpose: turns a resolved channel and pairing into switch positions
// Assumes: inputs already resolved for pairs and sequencing mode
// Notes: purely combinational, caller registers the result
`timescale 1ns/10ps
module mux_route_decode (
  // selection
  input wire logic temp_sel,
  input wire logic [3:0] chan,
  input wire logic [1:0] pair,
  // switch positions, one-hot
  output logic [16:0] pos_sw,
  output logic [17:0] neg_sw
);
  import chan_mux_pkg::*;

  logic [3:0] odd_chan;
  logic use_com;
  logic use_odd;
  assign odd_chan = {chan[3:1], 1'b1};
  assign use_com = !temp_sel && (pair == PAIR_COMMON);
  assign use_odd = !temp_sel && (pair == PAIR_EVEN_ODD) && !chan[0];

  genvar i;
  generate
    for (i = 0; i < NUM_INPUTS; i++) begin : g_in
      assign pos_sw[i] = !temp_sel && (chan == 4'(i));
      assign neg_sw[i] = use_odd && (odd_chan == 4'(i));
    end
  endgenerate

  assign pos_sw[POS_TEMP_POS] = temp_sel;
  assign neg_sw[NEG_COM_POS] = use_com;
  assign neg_sw[NEG_GND_POS] = !use_com && !use_odd;
endmodule : mux_route_decode
